// File: rtl/cbh_defs.vh
// Constants for the bridge configuration header middle block.
`ifndef CBH_DEFS_VH
`define CBH_DEFS_VH
`define CBH_OFS_LATENCY 8'h0D
`define CBH_OFS_HDRTYPE 8'h0E
`define CBH_OFS_SELFTEST 8'h0F
`define CBH_OFS_SOCKBASE 8'h10
`define CBH_OFS_CAPPTR 8'h14
`define CBH_OFS_CARDSTAT 8'h16
`define CBH_OFS_PM0 8'hA0
`define CBH_OFS_PM1 8'hA4
`define CBH_HDR_LAST 8'h7F
`define CBH_LATENCY_RST 8'h00
`define CBH_HDRTYPE_VAL 8'h82
`define CBH_SELFTEST_VAL 8'h00
`define CBH_CAPPTR_VAL 8'hA0
`define CBH_SOCKBASE_RST 20'h0_0000
`define CBH_SOCKBASE_MSB 31
`define CBH_SOCKBASE_LSB 12
`define CBH_LEGACY_OFS 12'h800
`define CBH_STAT_RST 16'h0200
`define CBH_STAT_SPEED 16'h0200
`define CBH_STAT_W1C_MASK 16'hF900
`define CBH_BIT_PARITY 15
`define CBH_BIT_SYSERR 14
`define CBH_BIT_MABORT 13
`define CBH_BIT_TA_REC 12
`define CBH_BIT_TA_SIG 11
`define CBH_BIT_DPAR 8
`define CBH_FN_COUNT 2
`define CBH_DW_LATENCY 6'h03
`define CBH_DW_SOCKBASE 6'h04
`define CBH_DW_CAPSTAT 6'h05
`define CBH_DW_PM0 6'h28
`define CBH_DW_PM1 6'h29
`define CBH_WINDOW_OFF 20'h0_0000
`define CBH_CACHE_LINE_VAL 8'h00
`define CBH_CAP_GAP_VAL 8'h00
`define CBH_READ_IDLE 32'h0000_0000
`endif

// File: rtl/cbh_latency_timer.v
// Per-function primary bus latency counter with forced-termination request.
`timescale 1ns/1ps
`default_nettype none
module cbh_latency_timer (
  // Clock and reset.
  input wire mclk,
  input wire reset_n,
  // Bus activity of this function.
  input wire [7:0] limit,
  input wire frame_start,
  input wire master_active,
  input wire gnt_n,
  // Termination request.
  output reg expired_reg,
  output wire terminate_req
);
  reg [7:0] count_reg;

  // Count restarts at zero on each FRAME assertion and advances once per clock while this function is master.
  always @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      count_reg <= 8'h00;
      expired_reg <= 1'b0;
    end
    else if (frame_start)
    begin
      count_reg <= 8'h00;
      expired_reg <= (limit == 8'h00);
    end
    else if (master_active)
    begin
      if (count_reg != 8'hFF)
        count_reg <= count_reg + 8'h01;
      if (count_reg + 8'h01 >= limit)
        expired_reg <= 1'b1;
    end
    else
      expired_reg <= 1'b0;
  end

  // Once expired, the transfer ends as soon as the arbiter withdraws grant.
  assign terminate_req = master_active && expired_reg && gnt_n;
endmodule // cbh_latency_timer
`default_nettype wire

// File: rtl/cbh_config_mid.v
// Configuration header registers 0Dh to 17h for both bridge functions.
//
// Summary of operation
// - Latency timer at 0Dh, read/write, resets zero.
// - Latency count restarts on FRAME, counts clocks while master.
// - Expired count ends transfer when grant drops.
// - Each function keeps its own latency timer.
// - Header type at 0Eh reads 82h always.
// - Header 00h-7Fh; 80h-FFh is extension space.
// - Self-test register at 0Fh reads 00h.
// - Socket base bits 31-12 writable, reset zero.
// - Socket base bits 11-0 read zero.
// - Socket window: registers 000h, legacy set 800h.
// - Each function has its own socket base.
// - Capability pointer at 14h reads A0h.
// - Power-management words live at A0h and A4h.
// - Card status resets 0200h; flags write-one-clear.
// - Bit 15 sets on card parity error.
// - Bit 14 sets on card CSERR; never driven.
// - Bit 13 sets on our master abort.
// - Bit 12 sets on received target abort.
// - Bit 11 sets on signalled target abort.
// - Bits 10-9 hardwired to 01b.
// - Bit 8 needs CPERR, mastership, response enable.
// - Bits 7-0 read zero.
`timescale 1ns/1ps
`default_nettype none
`include "cbh_defs.vh"
module cbh_config_mid (
  // Clock and reset.
  input wire mclk,
  input wire reset_n,
  // Configuration access port, one dword per access.
  input wire cfg_sel,
  input wire cfg_fn,
  input wire [7:0] cfg_addr,
  input wire cfg_wr,
  input wire cfg_rd,
  input wire [3:0] cfg_be,
  input wire [31:0] cfg_wdata,
  output reg [31:0] cfg_rdata_reg,
  output reg cfg_ack_reg,
  output wire cfg_ext_sel,
  // Power-management capability dwords from outside.
  input wire [31:0] pm_dword0_f0,
  input wire [31:0] pm_dword1_f0,
  input wire [31:0] pm_dword0_f1,
  input wire [31:0] pm_dword1_f1,
  // Primary bus master activity, one bit per function.
  input wire [1:0] frame_start,
  input wire [1:0] master_active,
  input wire [1:0] gnt_n,
  output wire [1:0] latency_terminate,
  // Memory decode of the socket windows.
  input wire [31:0] mem_addr,
  output wire [1:0] sock_reg_hit,
  output wire [1:0] legacy_socket_registers_hit,
  // Card bus events, one bit per function.
  input wire [1:0] card_parity_event,
  input wire [1:0] card_serr_n,
  input wire [1:0] card_master_abort_event,
  input wire [1:0] card_ta_received_event,
  input wire [1:0] card_ta_signaled_event,
  input wire [1:0] card_perr_event,
  input wire [1:0] card_bus_master,
  input wire [1:0] parity_response_en,
  // The device never drives the card system error line.
  output wire [1:0] card_serr_oe
);
  // Per-function register storage, indexed by function number.
  reg [7:0] primary_latency_timer_reg [0:1];
  reg [19:0] socket_window_base_reg [0:1];
  reg [15:0] card_side_status_reg [0:1];

  // Read path: the word that the next read will return.
  reg [31:0] rdata_next;

  // Access decode shared by both functions.
  wire [5:0] cfg_dword;
  wire in_extension;
  wire hit_latency;
  wire hit_sockbase;
  wire hit_capstat;
  wire hit_pm0;
  wire hit_pm1;
  wire cfg_taken;
  wire read_taken;
  wire ack_next;

  // Per-function views of the stored registers.
  wire [7:0] lat_f0;
  wire [7:0] lat_f1;
  wire [31:0] base_f0;
  wire [31:0] base_f1;
  wire [15:0] status_f0;
  wire [15:0] status_f1;

  // Views of the function addressed by the current access.
  wire [7:0] lat_sel;
  wire [31:0] base_sel;
  wire [15:0] status_sel;
  wire [31:0] pm0_sel;
  wire [31:0] pm1_sel;

  // Byte lanes of the dword at 0Ch, assembled from fixed values and the timer.
  wire [7:0] lane_cache_line;
  wire [7:0] lane_header_type;
  wire [7:0] lane_self_test;
  wire [31:0] word_latency;

  // Byte lanes of the dword at 14h: pointer, a gap, then the card status.
  wire [7:0] lane_cap_pointer;
  wire [7:0] lane_cap_gap;
  wire [31:0] word_capstat;

  // The device never drives the card system error line, so its enable is tied off.
  assign card_serr_oe = 2'b00;

  // Dword decode; the header fields of this slice fall in three dwords, plus the two power-management dwords.
  assign cfg_dword = cfg_addr[7:2];
  assign in_extension = (cfg_addr > `CBH_HDR_LAST);
  assign hit_latency = (cfg_dword == `CBH_DW_LATENCY);
  assign hit_sockbase = (cfg_dword == `CBH_DW_SOCKBASE);
  assign hit_capstat = (cfg_dword == `CBH_DW_CAPSTAT);
  assign hit_pm0 = (cfg_dword == `CBH_DW_PM0);
  assign hit_pm1 = (cfg_dword == `CBH_DW_PM1);

  // Extension space goes to the device-specific block, except the two power-management
  // dwords, which stay here because the capability pointer leads software to them.
  assign cfg_ext_sel = cfg_sel && in_extension && !hit_pm0 && !hit_pm1;

  // An access is ours when selected with a command and not routed to the extension block.
  assign cfg_taken = cfg_sel && (cfg_rd || cfg_wr) && !cfg_ext_sel;
  assign read_taken = cfg_taken && cfg_rd;

  // Every taken access is answered, reads and writes alike, so the host never stalls.
  assign ack_next = cfg_taken;

  genvar fn;
  generate
    for (fn = 0; fn < `CBH_FN_COUNT; fn = fn + 1)
    begin : g_fn
      // Function number of this copy, sized to match the select input.
      localparam [0:0] FN_ID = fn;

      // Write strobes per byte lane of this function.
      wire wr_this;
      wire lat_wr;
      wire base_wr_mid;
      wire base_wr_upper;
      wire base_wr_top;
      wire stat_wr_lo;
      wire stat_wr_hi;

      // Next values of this function's registers.
      wire [7:0] lat_next;
      wire [19:0] base_next;
      wire [15:0] status_next;

      // Card-side events that raise the sticky flags of this function.
      wire parity_set;
      wire syserr_set;
      wire mabort_set;
      wire ta_rec_set;
      wire ta_sig_set;
      wire dpar_set;

      // Flag sources and software clears, one bit per status position.
      wire [15:0] set_bits;
      wire [15:0] clr_bits;

      // Window decode.
      wire window_on;
      wire window_match;

      // Lane strobes; a lane that is not enabled leaves its byte untouched.
      assign wr_this = cfg_taken && cfg_wr && (cfg_fn == FN_ID);
      assign lat_wr = wr_this && hit_latency && cfg_be[1];
      assign base_wr_mid = wr_this && hit_sockbase && cfg_be[1];
      assign base_wr_upper = wr_this && hit_sockbase && cfg_be[2];
      assign base_wr_top = wr_this && hit_sockbase && cfg_be[3];
      assign stat_wr_lo = wr_this && hit_capstat && cfg_be[2];
      assign stat_wr_hi = wr_this && hit_capstat && cfg_be[3];

      // Latency limit: a plain read/write byte.
      assign lat_next = lat_wr ? cfg_wdata[15:8] : primary_latency_timer_reg[fn];

      // Socket base: bits 31-12 only; the low twelve bits have no storage, so writes there vanish.
      assign base_next[3:0] = base_wr_mid ? cfg_wdata[15:12] : socket_window_base_reg[fn][3:0];
      assign base_next[11:4] = base_wr_upper ? cfg_wdata[23:16] : socket_window_base_reg[fn][11:4];
      assign base_next[19:12] = base_wr_top ? cfg_wdata[31:24] : socket_window_base_reg[fn][19:12];

      // Event sources; the card system error line is active low.
      assign parity_set = card_parity_event[fn];
      assign syserr_set = ~card_serr_n[fn];
      assign mabort_set = card_master_abort_event[fn];
      assign ta_rec_set = card_ta_received_event[fn];
      assign ta_sig_set = card_ta_signaled_event[fn];
      assign dpar_set = card_perr_event[fn] && card_bus_master[fn] && parity_response_en[fn];

      // Place the sources at their status positions; fixed positions get no source.
      assign set_bits[`CBH_BIT_PARITY] = parity_set;
      assign set_bits[`CBH_BIT_SYSERR] = syserr_set;
      assign set_bits[`CBH_BIT_MABORT] = mabort_set;
      assign set_bits[`CBH_BIT_TA_REC] = ta_rec_set;
      assign set_bits[`CBH_BIT_TA_SIG] = ta_sig_set;
      assign set_bits[10:9] = 2'b00;
      assign set_bits[`CBH_BIT_DPAR] = dpar_set;
      assign set_bits[7:0] = 8'h00;

      // A software clear reaches only flag positions in enabled lanes; zeros clear nothing.
      assign clr_bits = {(stat_wr_hi ? cfg_wdata[31:24] : 8'h00), (stat_wr_lo ? cfg_wdata[23:16] : 8'h00)} &
        `CBH_STAT_W1C_MASK;

      // Flags are sticky and an event in the clearing cycle wins, so no event is ever lost.
      assign status_next = (card_side_status_reg[fn] & ~clr_bits & `CBH_STAT_W1C_MASK) |
        (set_bits & `CBH_STAT_W1C_MASK) | `CBH_STAT_SPEED;

      // A zero base keeps the window closed, so reset never claims the bottom of memory.
      assign window_on = (socket_window_base_reg[fn] != `CBH_WINDOW_OFF);
      assign window_match = window_on &&
        (mem_addr[`CBH_SOCKBASE_MSB:`CBH_SOCKBASE_LSB] == socket_window_base_reg[fn]);

      // Low half of the window is the socket registers, upper half the legacy set.
      assign sock_reg_hit[fn] = window_match &&
        (mem_addr[`CBH_SOCKBASE_LSB-1:0] < `CBH_LEGACY_OFS);
      assign legacy_socket_registers_hit[fn] = window_match &&
        (mem_addr[`CBH_SOCKBASE_LSB-1:0] >= `CBH_LEGACY_OFS);

      // Each function owns its timer, so the platform can rank the two functions differently.
      cbh_latency_timer u_lat (
        .mclk(mclk),
        .reset_n(reset_n),
        .limit(primary_latency_timer_reg[fn]),
        .frame_start(frame_start[fn]),
        .master_active(master_active[fn]),
        .gnt_n(gnt_n[fn]),
        .expired_reg(),
        .terminate_req(latency_terminate[fn])
      );

      // Latency limit register.
      always @(posedge mclk or negedge reset_n)
      begin
        if (!reset_n)
          primary_latency_timer_reg[fn] <= `CBH_LATENCY_RST;
        else
          primary_latency_timer_reg[fn] <= lat_next;
      end

      // Socket base register, one per function.
      always @(posedge mclk or negedge reset_n)
      begin
        if (!reset_n)
          socket_window_base_reg[fn] <= `CBH_SOCKBASE_RST;
        else
          socket_window_base_reg[fn] <= base_next;
      end

      // Card status register.
      always @(posedge mclk or negedge reset_n)
      begin
        if (!reset_n)
          card_side_status_reg[fn] <= `CBH_STAT_RST;
        else
          card_side_status_reg[fn] <= status_next;
      end
    end
  endgenerate

  // Per-function views; the base reads back with its low twelve bits as zero.
  assign lat_f0 = primary_latency_timer_reg[0];
  assign lat_f1 = primary_latency_timer_reg[1];
  assign base_f0 = {socket_window_base_reg[0], 12'h000};
  assign base_f1 = {socket_window_base_reg[1], 12'h000};
  assign status_f0 = card_side_status_reg[0];
  assign status_f1 = card_side_status_reg[1];

  // Pick the addressed function.
  assign lat_sel = cfg_fn ? lat_f1 : lat_f0;
  assign base_sel = cfg_fn ? base_f1 : base_f0;
  assign status_sel = cfg_fn ? status_f1 : status_f0;
  assign pm0_sel = cfg_fn ? pm_dword0_f1 : pm_dword0_f0;
  assign pm1_sel = cfg_fn ? pm_dword1_f1 : pm_dword1_f0;

  // The cache line byte belongs to another block and reads zero in this slice.
  assign lane_cache_line = `CBH_CACHE_LINE_VAL;
  assign lane_header_type = `CBH_HDRTYPE_VAL;
  assign lane_self_test = `CBH_SELFTEST_VAL;
  assign word_latency = {lane_self_test, lane_header_type, lat_sel, lane_cache_line};

  // The byte between pointer and status is outside this slice and reads zero.
  assign lane_cap_pointer = `CBH_CAPPTR_VAL;
  assign lane_cap_gap = `CBH_CAP_GAP_VAL;
  assign word_capstat = {status_sel, lane_cap_gap, lane_cap_pointer};

  // Read multiplexer; unmapped header dwords in this slice read zero.
  always @*
  begin
    rdata_next = `CBH_READ_IDLE;
    case (cfg_dword)
      `CBH_DW_LATENCY:
        rdata_next = word_latency;
      `CBH_DW_SOCKBASE:
        rdata_next = base_sel;
      `CBH_DW_CAPSTAT:
        rdata_next = word_capstat;
      `CBH_DW_PM0:
        rdata_next = pm0_sel;
      `CBH_DW_PM1:
        rdata_next = pm1_sel;
      default:
        rdata_next = `CBH_READ_IDLE;
    endcase
  end

  // Acknowledge is registered, one cycle after the request.
  always @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      cfg_ack_reg <= 1'b0;
    else
      cfg_ack_reg <= ack_next;
  end

  // Read data is captured only on reads, so it holds until the next read.
  always @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      cfg_rdata_reg <= `CBH_READ_IDLE;
    else if (read_taken)
      cfg_rdata_reg <= rdata_next;
  end
endmodule // cbh_config_mid
`default_nettype wire

// File: sim/cbh_mid_monitor.sv
// Checker for the configuration header middle block.
`timescale 1ns/1ps
`default_nettype none
module cbh_mid_monitor (
  // Clock, reset and access port.
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic cfg_sel,
  input wire logic cfg_rd,
  input wire logic cfg_wr,
  input wire logic [7:0] cfg_addr,
  input wire logic [31:0] cfg_rdata_reg,
  input wire logic cfg_ack_reg,
  input wire logic cfg_ext_sel,
  // Side outputs and their causes.
  input wire logic [1:0] master_active,
  input wire logic [1:0] gnt_n,
  input wire logic [1:0] latency_terminate,
  input wire logic [31:0] mem_addr,
  input wire logic [1:0] legacy_socket_registers_hit,
  input wire logic [1:0] card_serr_oe
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  // A taken access is a select with a command that is not routed to the extension block.
  wire tk = cfg_sel && (cfg_rd || cfg_wr) && !cfg_ext_sel;
  wire rd = tk && cfg_rd;
  wire [5:0] dw = cfg_addr[7:2];
  ack_follows_a: assert property (tk |=> cfg_ack_reg) else $error("no ack");
  ext_silent_a: assert property (cfg_sel && cfg_ext_sel |=> !cfg_ack_reg) else $error("ext ack");
  ext_decode_a: assert property (cfg_ext_sel == (cfg_sel && cfg_addr > 8'h7F && cfg_addr[7:3] != 5'h14))
    else $error("ext decode");
  hdr_const_a: assert property (rd && dw == 6'h03 |=> cfg_rdata_reg[31:16] == 16'h0082)
    else $error("hdr const");
  cap_stat_a: assert property (rd && dw == 6'h05 |=> cfg_rdata_reg[7:0] == 8'hA0
    && cfg_rdata_reg[26:25] == 2'b01 && cfg_rdata_reg[23:16] == 8'h00) else $error("cap stat");
  base_low_a: assert property (rd && dw == 6'h04 |=> cfg_rdata_reg[11:0] == 12'h000)
    else $error("base low");
  serr_quiet_a: assert property (card_serr_oe == 2'b00) else $error("serr");
  term_cause_a: assert property (latency_terminate[0] |-> master_active[0] && gnt_n[0])
    else $error("term");
  window_half_a: assert property (legacy_socket_registers_hit[0] |-> mem_addr[11])
    else $error("legacy");
  cover property (tk ##1 cfg_ack_reg);
  cover property (latency_terminate[0]);
  cover property (legacy_socket_registers_hit[1]);
endmodule // cbh_mid_monitor
bind cbh_config_mid cbh_mid_monitor u_mon (.mclk, .reset_n, .cfg_sel, .cfg_rd, .cfg_wr, .cfg_addr,
  .cfg_rdata_reg, .cfg_ack_reg, .cfg_ext_sel, .master_active, .gnt_n, .latency_terminate, .mem_addr,
  .legacy_socket_registers_hit, .card_serr_oe);
`default_nettype wire

// File: sim/tb.sv
// Self-checking bench for the configuration header middle block.
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic mclk, reset_n, cfg_sel, cfg_fn, cfg_wr, cfg_rd;
  logic [7:0] cfg_addr;
  logic [3:0] cfg_be;
  logic [31:0] cfg_wdata, mem_addr, pm0, pm1, rd;
  logic [1:0] fs, ma, gn, bm, pre;
  logic [11:0] ev;
  wire [31:0] rdata;
  wire ack, ext;
  wire [1:0] term, sh, lh, oe;
  integer num_errors = 0, checks = 0, i, n;
  cbh_config_mid dut (.mclk, .reset_n, .cfg_sel, .cfg_fn, .cfg_addr, .cfg_wr, .cfg_rd, .cfg_be,
    .cfg_wdata, .cfg_rdata_reg(rdata), .cfg_ack_reg(ack), .cfg_ext_sel(ext), .pm_dword0_f0(pm0),
    .pm_dword1_f0(pm1), .pm_dword0_f1(~pm0), .pm_dword1_f1(~pm1), .frame_start(fs), .master_active(ma),
    .gnt_n(gn), .latency_terminate(term), .mem_addr, .sock_reg_hit(sh), .legacy_socket_registers_hit(lh),
    .card_parity_event(ev[1:0]), .card_serr_n(~ev[3:2]), .card_master_abort_event(ev[5:4]),
    .card_ta_received_event(ev[7:6]), .card_ta_signaled_event(ev[9:8]), .card_perr_event(ev[11:10]),
    .card_bus_master(bm), .parity_response_en(pre), .card_serr_oe(oe));
  // Free-running clock at 25 MHz.
  initial
  begin
    mclk = 0;
    forever #20 mclk = ~mclk;
  end
  // Compare and count.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // One access: strobe for one cycle, ack is due one cycle later.
  task automatic acc(input logic f, w, input logic [7:0] a, input logic [3:0] b, input logic [31:0] d, k);
    {cfg_fn, cfg_wr, cfg_rd, cfg_addr, cfg_be, cfg_wdata, cfg_sel} = {f, w, !w, a, b, d, 1'b1};
    @(posedge mclk);
    #1 cfg_sel = 0;
    chk(32'(ack), k);
    rd = rdata;
    @(posedge mclk);
    #1;
  endtask
  task automatic rchk(input logic f, input logic [7:0] a, input logic [31:0] m, e);
    acc(f, 0, a, 4'hF, 32'h0, 1);
    chk(rd & m, e);
  endtask
  task automatic dec(input logic [31:0] a, input logic [3:0] e);
    mem_addr = a;
    #1 chk(32'({lh, sh}), 32'(e));
  endtask
  // Single exit point for the run.
  task automatic report_and_stop;
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Main sequence.
  initial
  begin
    {reset_n, cfg_sel, cfg_fn, cfg_wr, cfg_rd, cfg_addr, cfg_be, cfg_wdata, fs, ev, mem_addr} = '0;
    {ma, gn, bm, pre, pm0, pm1} = {8'b0100_1111, 32'h1357_9BDF, 32'h2468_ACE0};
    repeat (6) @(posedge mclk);
    #1 reset_n = 1;
    rchk(0, 8'h0C, 32'hFFFF_FF00, 32'h0082_0000);
    rchk(1, 8'h10, 32'hFFFF_FFFF, 32'h0);
    rchk(0, 8'h14, 32'hFFFF_00FF, 32'h0200_00A0);
    $display("reset values done");
    acc(0, 1, 8'h0C, 4'hE, 32'hFFFF_05FF, 1);
    acc(1, 1, 8'h0C, 4'h2, 32'h0000_0900, 1);
    rchk(0, 8'h0C, 32'hFFFF_FF00, 32'h0082_0500);
    rchk(1, 8'h0C, 32'hFFFF_FF00, 32'h0082_0900);
    acc(0, 1, 8'h10, 4'hF, 32'hFFFF_FFFF, 1);
    rchk(0, 8'h10, 32'hFFFF_FFFF, 32'hFFFF_F000);
    rchk(1, 8'h10, 32'hFFFF_FFFF, 32'h0);
    acc(0, 1, 8'h10, 4'hF, 32'h1234_5ABC, 1);
    acc(1, 1, 8'h10, 4'hF, 32'h0004_0000, 1);
    dec(32'h1234_5010, 4'b0001);
    dec(32'h1234_5810, 4'b0100);
    dec(32'h0004_0800, 4'b1000);
    dec(32'h0004_0010, 4'b0010);
    rchk(1, 8'hA4, 32'hFFFF_FFFF, ~pm1);
    acc(0, 0, 8'h80, 4'hF, 32'h0, 0);
    $display("registers and decode done");
    fs = 2'b01;
    @(posedge mclk);
    #1 fs = 0;
    repeat (8) @(posedge mclk);
    #1 chk(32'(term), 32'h0);
    gn = 2'b11;
    #1 chk(32'(term), 32'h1);
    fs = 2'b01;
    @(posedge mclk);
    #1 fs = 0;
    chk(32'(term), 32'h0);
    for (n = 0; n < 12 && term[0] !== 1'b1; n++)
    begin
      @(posedge mclk);
      #1;
    end
    chk(n, 32'h0000_0005);
    $display("latency done");
    for (i = 0; i < 6; i++)
    begin
      ev = 12'h1 << (2 * i);
      @(posedge mclk);
      #1 ev = 0;
      rchk(0, 8'h14, 32'hFFFF_0000, {(i < 5 ? 16'h8000 >> i : 16'h0100) | 16'h0200, 16'h0});
      acc(0, 1, 8'h14, 4'hC, 32'h00FF_0000, 1);
      rchk(0, 8'h14, 32'hFFFF_0000, {(i < 5 ? 16'h8000 >> i : 16'h0100) | 16'h0200, 16'h0});
      acc(0, 1, 8'h14, 4'hC, 32'hFFFF_0000, 1);
      rchk(0, 8'h14, 32'hFFFF_0000, 32'h0200_0000);
    end
    rchk(1, 8'h14, 32'hFFFF_0000, 32'h0200_0000);
    bm = 0;
    ev = 12'h400;
    @(posedge mclk);
    #1 ev = 0;
    rchk(0, 8'h14, 32'hFFFF_0000, 32'h0200_0000);
    $display("status done");
    report_and_stop();
  end
endmodule // tb
`default_nettype wire
